/* File: common/lbst_consts.svh */
// constants of the lin break and sync timer
`ifndef LBST_CONSTS_SVH
`define LBST_CONSTS_SVH
// ************************************
// register byte addresses
// ************************************
`define LBST_ADDR_CTRL      32'hFFFF0780
`define LBST_ADDR_STATUS    32'hFFFF0784
`define LBST_ADDR_SYNC      32'hFFFF0788
`define LBST_ADDR_EDGE      32'hFFFF078C
`define LBST_ADDR_BREAK     32'hFFFF0790
`define LBST_ADDR_MASK      32'hFFFF0794
// ************************************
// fields
// ************************************
`define LBST_CTRL_ENABLE    0
`define LBST_CTRL_STOP_RISE 1
`define LBST_ST_BREAK       0
`define LBST_ST_STOP        1
`define LBST_ST_BREAK_ERR   4
`define LBST_EDGE_START_LSB 0
`define LBST_EDGE_STOP_LSB  4
// ************************************
// reset values
// ************************************
`define LBST_RST_CTRL       8'h00
`define LBST_RST_EDGE       8'h32
`define LBST_RST_CMP        12'h047
`define LBST_RST_MASK       8'h00
// ************************************
// timing
// ************************************
`define LBST_CLK_HZ         100000000
`define LBST_SYNC_HZ        5000000
`define LBST_LPO_HZ         131000
`define LBST_SYNC_DIV       (`LBST_CLK_HZ / `LBST_SYNC_HZ)
`define LBST_LPO_DIV        (`LBST_CLK_HZ / `LBST_LPO_HZ)
`define LBST_BAUD_BPS       20000
`define LBST_BIT_CYCLES     (`LBST_CLK_HZ / `LBST_BAUD_BPS)
`define LBST_BREAK_BITS     13
`define LBST_SYNC_BYTE      8'h55
`endif

/* File: common/lbst_pkg.sv */
// types of the lin break and sync timer
package lbst_pkg;
  typedef enum logic [1:0] {
    LBST_IDLE,
    LBST_BREAK,
    LBST_DELIM,
    LBST_BYTE
  } lbst_mst_e;

  typedef struct packed {
    logic [2:0]  bus_sync;
    logic [7:0]  ctrl;
    logic [7:0]  edge_cfg;
    logic [11:0] cmp;
    logic [7:0]  mask;
    logic [7:0]  status;
    logic [11:0] brk_cnt;
    logic        brk_low;
    logic        hit_done;
    logic        armed;
    logic        run;
    logic [3:0]  fcnt;
    logic [3:0]  rcnt;
    logic [15:0] sync_cnt;
    logic [31:0] rdata;
    logic        irq;
  } lbst_dev_s;

  typedef struct packed {
    lbst_mst_e   st;
    logic [4:0]  bit_cnt;
    logic [9:0]  shf;
    logic [3:0]  bitn;
    logic [3:0]  idx;
    logic [3:0]  len;
    logic [5:0]  id;
    logic [63:0] data;
    logic        drive;
    logic        done;
  } lbst_mst_s;
endpackage

/* File: common/lbst_if.sv */
// single-wire lin bus between master and slave
`timescale 1ns/10ps
interface lbst_if;
  logic m_o;
  logic m_oe;
  logic lin;
  // pulled up, low while the master drives
  assign lin = m_oe ? m_o : 1'b1;
  modport master (output m_o, output m_oe, input lin);
  modport device (input lin);
endinterface

/* File: hw/lbst_tick.sv */
// divider making a one-cycle enable pulse
`timescale 1ns/10ps
module lbst_tick #(
  parameter int DIV = 20
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_clear,
  output logic      o_tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  // restart value that keeps the first period after a clear full length
  localparam logic [W-1:0] FIRST = (DIV > 1) ? W'(1) : W'(0);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } lbst_tick_s;

  lbst_tick_s r;
  lbst_tick_s n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (i_clear) begin
      n.cnt = FIRST;
    end else if (r.cnt == LAST) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_tick = r.tick;
endmodule

/* File: hw/lbst_device.sv */
// lin slave break timer and sync edge timer
// What this block does
// - stop edge count in upper nibble, selectable polarity
// - stop count resets to three
// - start count lower nibble, resets to two
// - break falling edge counts as edge one
// - 16-bit read-only sync timer at 5 MHz
// - break location read returns 12-bit count
// - falling edge or read clears break timer
// - break location write loads compare only
// - compare match sets break status, interrupt
// - break timer runs on until rising edge
// - overflow without rising edge flags break error
// - compare resets to 0x47
// - sync timing only after valid break
// - master breaks 13 bits; slave detects it at the reset compare once enabled
// - baud from first to fifth sync fall
// - master sends 6-bit id with parity
// - one to eight data bytes per frame
`timescale 1ns/10ps
`include "lbst_consts.svh"
module lbst_device
  import lbst_pkg::*;
#(
  parameter int SYNC_DIV = `LBST_SYNC_DIV,
  parameter int LPO_DIV  = `LBST_LPO_DIV
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // lin bus
  lbst_if.device           lin,
  // register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // interrupt
  output logic             o_irq
);
  function automatic logic [3:0] inc4(input logic [3:0] v);
    inc4 = (v == 4'hF) ? v : v + 4'h1;
  endfunction

  lbst_dev_s r;
  lbst_dev_s n;
  logic      sync_tick;
  logic      lpo_tick;

  // ************************************
  // time bases
  // ************************************
  lbst_tick #(.DIV(SYNC_DIV)) u_sync_tick (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_clear (1'b0),
    .o_tick  (sync_tick)
  );

  lbst_tick #(.DIV(LPO_DIV)) u_lpo_tick (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_clear (1'b0),
    .o_tick  (lpo_tick)
  );

  // ************************************
  // next state
  // ************************************
  logic       bus;
  logic       fall;
  logic       rise;
  logic       stop_rise;
  logic       en;
  logic [3:0] start_n;
  logic [3:0] stop_n;
  logic [3:0] f_next;
  logic [3:0] r_next;
  logic [7:0] ev;
  logic [7:0] clr;

  always_comb begin
    n = r;
    n.rdata = '0;
    ev = '0;
    clr = '0;
    n.bus_sync = {r.bus_sync[1:0], lin.lin};
    bus = r.bus_sync[1];
    fall = r.bus_sync[2] & ~bus;
    rise = ~r.bus_sync[2] & bus;
    en = r.ctrl[`LBST_CTRL_ENABLE];
    stop_rise = r.ctrl[`LBST_CTRL_STOP_RISE];
    start_n = r.edge_cfg[`LBST_EDGE_START_LSB +: 4];
    stop_n = r.edge_cfg[`LBST_EDGE_STOP_LSB +: 4];
    f_next = inc4(r.fcnt);
    r_next = inc4(r.rcnt);
    // break timer
    if (fall) begin
      n.brk_cnt = '0;
      n.brk_low = 1'b1;
      n.hit_done = 1'b0;
    end else if (rise) begin
      n.brk_low = 1'b0;
    end else if (r.brk_low && lpo_tick) begin
      if (r.brk_cnt == 12'hFFF) begin
        ev[`LBST_ST_BREAK_ERR] = en;
        n.brk_low = 1'b0;
        n.armed = 1'b0;
        n.run = 1'b0;
      end else begin
        n.brk_cnt = r.brk_cnt + 12'h001;
      end
    end
    // edge counting inside an armed sequence
    if (r.armed && fall) begin
      n.fcnt = f_next;
      if (f_next == start_n && !r.run) begin
        n.run = 1'b1;
        n.sync_cnt = '0;
      end
    end
    if (r.armed && rise) begin
      n.rcnt = r_next;
    end
    if (r.armed && r.run && ((fall && !stop_rise && f_next == stop_n) ||
                             (rise && stop_rise && r_next == stop_n))) begin
      n.run = 1'b0;
      n.armed = 1'b0;
      ev[`LBST_ST_STOP] = 1'b1;
    end
    if (r.run && sync_tick && r.sync_cnt != 16'hFFFF) begin
      n.sync_cnt = r.sync_cnt + 16'h0001;
    end
    // compare match marks a valid break, even mid-frame
    if (en && r.brk_low && !r.hit_done && !fall && r.brk_cnt == r.cmp) begin
      ev[`LBST_ST_BREAK] = 1'b1;
      n.hit_done = 1'b1;
      n.armed = 1'b1;
      n.fcnt = 4'h1;
      n.rcnt = 4'h0;
      n.run = (start_n <= 4'h1);
      n.sync_cnt = '0;
    end
    // register writes
    if (i_wr) begin
      case (i_addr)
        `LBST_ADDR_CTRL: begin
          n.ctrl = i_wdata[7:0];
        end
        `LBST_ADDR_EDGE: begin
          n.edge_cfg = i_wdata[7:0];
        end
        `LBST_ADDR_BREAK: begin
          n.cmp = i_wdata[11:0];
        end
        `LBST_ADDR_MASK: begin
          n.mask = i_wdata[7:0];
        end
        `LBST_ADDR_STATUS: begin
          clr = i_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over clear
    n.status = (r.status & ~clr) | ev;
    // register reads
    if (i_rd) begin
      case (i_addr)
        `LBST_ADDR_CTRL: begin
          n.rdata = {24'h0, r.ctrl};
        end
        `LBST_ADDR_STATUS: begin
          n.rdata = {24'h0, r.status};
        end
        `LBST_ADDR_SYNC: begin
          n.rdata = {16'h0, r.sync_cnt};
        end
        `LBST_ADDR_EDGE: begin
          n.rdata = {24'h0, r.edge_cfg};
        end
        `LBST_ADDR_BREAK: begin
          n.rdata = {20'h0, r.brk_cnt};
          n.brk_cnt = '0;
        end
        `LBST_ADDR_MASK: begin
          n.rdata = {24'h0, r.mask};
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end
    n.irq = |(n.status & r.mask);
  end

  // ************************************
  // state register
  // ************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.bus_sync <= 3'b111;
      r.ctrl <= `LBST_RST_CTRL;
      r.edge_cfg <= `LBST_RST_EDGE;
      r.cmp <= `LBST_RST_CMP;
      r.mask <= `LBST_RST_MASK;
    end else begin
      r <= n;
    end
  end

  assign o_rdata = r.rdata;
  assign o_irq = r.irq;
endmodule

/* File: hw/lbst_master.sv */
// lin master frame generator: break, sync, id, data
`timescale 1ns/10ps
`include "lbst_consts.svh"
module lbst_master
  import lbst_pkg::*;
#(
  parameter int BIT_CYCLES = `LBST_BIT_CYCLES,
  parameter int BREAK_BITS = `LBST_BREAK_BITS
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // lin bus
  lbst_if.master           lin,
  // frame request
  input  wire logic        i_start,
  input  wire logic [5:0]  i_id,
  input  wire logic [3:0]  i_len,
  input  wire logic [63:0] i_data,
  // status
  output logic             o_busy,
  output logic             o_done
);
  localparam logic [4:0] BRK_LAST = 5'(BREAK_BITS - 1);

  function automatic logic [7:0] pid(input logic [5:0] id);
    pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  function automatic logic [9:0] frame(input logic [3:0] idx, input logic [5:0] id, input logic [63:0] d);
    logic [7:0] b;
    b = (idx == 4'h0) ? `LBST_SYNC_BYTE : (idx == 4'h1) ? pid(id) : d[8*(idx-4'h2) +: 8];
    frame = {1'b1, b, 1'b0};
  endfunction

  lbst_mst_s r;
  lbst_mst_s n;
  logic      bit_tick;
  logic      take;
  logic [9:0] f;

  lbst_tick #(.DIV(BIT_CYCLES)) u_bit_tick (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_clear (take),
    .o_tick  (bit_tick)
  );

  always_comb begin
    n = r;
    n.done = 1'b0;
    take = i_start && (r.st == LBST_IDLE);
    f = frame(4'h0, r.id, r.data);
    case (r.st)
      LBST_IDLE: begin
        if (take) begin
          n.st = LBST_BREAK;
          n.bit_cnt = '0;
          n.drive = 1'b1;
          n.id = i_id;
          n.data = i_data;
          n.len = (i_len == 4'h0) ? 4'h1 : (i_len > 4'h8) ? 4'h8 : i_len;
        end
      end
      LBST_BREAK: begin
        if (bit_tick) begin
          n.bit_cnt = r.bit_cnt + 5'h01;
          if (r.bit_cnt == BRK_LAST) begin
            n.st = LBST_DELIM;
            n.drive = 1'b0;
          end
        end
      end
      LBST_DELIM: begin
        if (bit_tick) begin
          n.st = LBST_BYTE;
          n.idx = 4'h0;
          n.bitn = 4'h0;
          n.shf = f;
          n.drive = ~f[0];
        end
      end
      LBST_BYTE: begin
        if (bit_tick) begin
          if (r.bitn == 4'h9) begin
            if (r.idx == r.len + 4'h1) begin
              n.st = LBST_IDLE;
              n.drive = 1'b0;
              n.done = 1'b1;
            end else begin
              f = frame(r.idx + 4'h1, r.id, r.data);
              n.idx = r.idx + 4'h1;
              n.bitn = 4'h0;
              n.shf = f;
              n.drive = ~f[0];
            end
          end else begin
            n.shf = {1'b1, r.shf[9:1]};
            n.bitn = r.bitn + 4'h1;
            n.drive = ~r.shf[1];
          end
        end
      end
      default: begin
        n.st = LBST_IDLE;
        n.drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.st <= LBST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign lin.m_o = 1'b0;
  assign lin.m_oe = r.drive;
  assign o_busy = (r.st != LBST_IDLE);
  assign o_done = r.done;
endmodule

/* File: verif/lbst_properties.sv */
// wire-level checks of the frames the master puts on the lin bus
`timescale 1ns/10ps
`include "lbst_consts.svh"
module lbst_properties #(
  parameter int BIT_CYCLES = `LBST_BIT_CYCLES,
  parameter int BREAK_BITS = `LBST_BREAK_BITS
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // bus
  input  wire logic m_o,
  input  wire logic m_oe,
  input  wire logic lin
);
  logic [15:0] lo_r;
  logic [15:0] hi_r;
  logic [3:0]  nlow_r;
  // run lengths of low and high levels, low runs since the break
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_r   <= 16'h0000;
      hi_r   <= 16'hFFFF;
      nlow_r <= 4'hF;
    end else begin
      lo_r <= m_oe ? lo_r + 16'h0001 : 16'h0000;
      hi_r <= m_oe ? 16'h0000 : (hi_r == 16'hFFFF ? hi_r : hi_r + 16'h0001);
      if (!m_oe && lo_r != 16'h0000) begin
        if (lo_r >= 16'(BREAK_BITS * BIT_CYCLES))
          nlow_r <= 4'h0;
        else if (nlow_r != 4'hF)
          nlow_r <= nlow_r + 4'h1;
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_low_end;
    $fell(m_oe);
  endsequence
  sequence s_high_end;
    $rose(m_oe);
  endsequence
  a_drive_low_only: assert property (m_oe |-> !m_o)
    else $error("master drives a high level");
  a_wire_level: assert property (lin == !m_oe)
    else $error("bus level differs from drive");
  a_break_length: assert property (s_low_end |->
    (lo_r <= 16'(9 * BIT_CYCLES) || lo_r >= 16'(BREAK_BITS * BIT_CYCLES)))
    else $error("low run neither character nor break");
  a_low_whole_bits: assert property (s_low_end |-> (lo_r % 16'(BIT_CYCLES)) == 16'h0000)
    else $error("low run not whole bits");
  a_high_min_bit: assert property (s_high_end |-> hi_r >= 16'(BIT_CYCLES))
    else $error("high run shorter than a bit");
  a_delim_one_bit: assert property (s_high_end ##0 (nlow_r == 4'h0) |-> hi_r == 16'(BIT_CYCLES))
    else $error("delimiter not one bit");
  a_sync_low_bits: assert property (s_low_end ##0 (nlow_r < 4'h5) |-> lo_r == 16'(BIT_CYCLES))
    else $error("sync low not one bit");
  a_sync_high_bits: assert property (s_high_end ##0 (nlow_r inside {[4'h1:4'h4]}) |->
    hi_r == 16'(BIT_CYCLES))
    else $error("sync high not one bit");
endmodule

/* File: verif/lin_break_sync_timer_bench.sv */
// bench: master frames into one device, a stuck bus on a second device
`timescale 1ns/10ps
`include "lbst_consts.svh"
module lin_break_sync_timer_bench;
  localparam int BC = 50;
  localparam int BB = `LBST_BREAK_BITS;
  localparam int SD = 4;
  localparam int LD = 8;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        start = 1'b0;
  logic [5:0]  id = 6'h0;
  logic [3:0]  len = 4'h1;
  logic [63:0] dat = 64'h0;
  logic [31:0] rdata, rdata_b, rv, rv_b, held;
  logic        irq, irq_b, busy, done;
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  logic [31:0] ra [7] = '{`LBST_ADDR_CTRL, `LBST_ADDR_STATUS, `LBST_ADDR_SYNC, `LBST_ADDR_EDGE,
                          `LBST_ADDR_BREAK, `LBST_ADDR_MASK, 32'hFFFF0798};
  logic [31:0] re [7] = '{32'h0, 32'h0, 32'h0, 32'h32, 32'h0, 32'h0, 32'h0};
  lbst_if bus();
  lbst_if bus_b();
  always #5 i_clock = ~i_clock;
  lbst_master #(.BIT_CYCLES(BC), .BREAK_BITS(BB)) i_lbst_master (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .lin(bus.master), .i_start(start), .i_id(id), .i_len(len), .i_data(dat),
    .o_busy(busy), .o_done(done));
  lbst_device #(.SYNC_DIV(SD), .LPO_DIV(LD)) i_lbst_device (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .lin(bus.device), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq));
  lbst_device #(.SYNC_DIV(SD), .LPO_DIV(LD)) i_lbst_device_b (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .lin(bus_b.device), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata_b),
    .o_irq(irq_b));
  lbst_properties #(.BIT_CYCLES(BC), .BREAK_BITS(BB)) i_lbst_properties (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .m_o(bus.m_o), .m_oe(bus.m_oe), .lin(bus.lin));
  // ************************************
  // tasks
  // ************************************
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_in(input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
    chk(32'(seen >= lo && seen <= hi), 32'h1);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge i_clock);
    wr_s  <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clock);
    rd_s <= 1'b0;
    #1;
    rv   = rdata;
    rv_b = rdata_b;
  endtask
  task automatic frame(input logic [5:0] i, input logic [3:0] l, input logic [63:0] d);
    @(posedge i_clock);
    id    <= i;
    len   <= l;
    dat   <= d;
    start <= 1'b1;
    @(posedge i_clock);
    start <= 1'b0;
    @(negedge i_clock);
    chk({31'h0, busy}, 32'h1);
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge i_clock);
      n++;
    end
    chk(32'(n < 20000), 32'h1);
    chk({31'h0, busy}, 32'h0);
  endtask
  // ************************************
  // timeout and main sequence
  // ************************************
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    bus_b.m_o  = 1'b0;
    bus_b.m_oe = 1'b0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      rd(ra[k]);
      chk(rv, re[k]);
    end
    wr(`LBST_ADDR_EDGE, 32'hA5);
    rd(`LBST_ADDR_EDGE);
    chk(rv, 32'hA5);
    wr(`LBST_ADDR_EDGE, 32'h32);
    wr(`LBST_ADDR_CTRL, 32'h1);
    wr(`LBST_ADDR_MASK, 32'h13);
    frame(6'h15, 4'h1, 64'h0123456789ABCDEF);
    rd(`LBST_ADDR_STATUS);
    chk(rv, 32'h03);
    chk({31'h0, irq}, 32'h1);
    rd(`LBST_ADDR_SYNC);
    chk_in(rv, 32'd24, 32'd26);
    held = rv;
    rd(`LBST_ADDR_SYNC);
    chk(rv, held);
    wr(`LBST_ADDR_STATUS, 32'h13);
    rd(`LBST_ADDR_STATUS);
    chk(rv, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`LBST_ADDR_EDGE, 32'h62);
    frame(6'h3C, 4'h8, 64'h0123456789ABCDEF);
    rd(`LBST_ADDR_SYNC);
    chk_in(rv, 32'd99, 32'd101);
    held = rv;
    wr(`LBST_ADDR_STATUS, 32'h13);
    wr(`LBST_ADDR_BREAK, 32'h7F);
    frame(6'h01, 4'h3, 64'h0123456789ABCDEF);
    rd(`LBST_ADDR_STATUS);
    chk(rv, 32'h0);
    rd(`LBST_ADDR_SYNC);
    chk(rv, held);
    // stop on the third rising edge, a zero data byte for the longest character low
    wr(`LBST_ADDR_BREAK, 32'h47);
    wr(`LBST_ADDR_CTRL, 32'h3);
    wr(`LBST_ADDR_EDGE, 32'h32);
    frame(6'h2A, 4'h2, 64'h000000000000FF00);
    rd(`LBST_ADDR_STATUS);
    chk(rv, 32'h03);
    rd(`LBST_ADDR_SYNC);
    chk_in(rv, 32'd36, 32'd39);
    wr(`LBST_ADDR_STATUS, 32'h13);
    wr(`LBST_ADDR_MASK, 32'h10);
    @(posedge i_clock);
    bus_b.m_oe <= 1'b1;
    repeat (1200) @(posedge i_clock);
    rd(`LBST_ADDR_BREAK);
    chk_in(rv_b, 32'd146, 32'd152);
    rd(`LBST_ADDR_BREAK);
    chk_in(rv_b, 32'd0, 32'd1);
    chk({31'h0, irq_b}, 32'h0);
    repeat (33000) @(posedge i_clock);
    rd(`LBST_ADDR_STATUS);
    chk(rv_b & 32'h10, 32'h10);
    chk({31'h0, irq_b}, 32'h1);
    bus_b.m_oe <= 1'b0;
    report_and_stop();
  end
endmodule
